// ==== tsd_defines.vh ====
`ifndef TSD_DEFINES_VH
`define TSD_DEFINES_VH

// Parameter defaults for the chain.
`define TSD_DEF_WIDTH 8
`define TSD_DEF_TAP_COUNT 4
`define TSD_DEF_TAP_DISTANCE 3
`define TSD_MIN_TAP_DISTANCE 3

// Register byte offsets on the AXI4-Lite port.
`define TSD_ADDR_W 8
`define TSD_ADDR_CTRL 8'h00
`define TSD_ADDR_CLEAR 8'h04
`define TSD_ADDR_PUSH 8'h08
`define TSD_ADDR_STATUS 8'h0c
`define TSD_ADDR_TAP_SEL 8'h10
`define TSD_ADDR_TAP_DATA 8'h14
`define TSD_ADDR_PARAMS 8'h18

// Control register fields and reset value.
`define TSD_CTRL_SRC_SW 0
`define TSD_CTRL_PIN_GATE 1
`define TSD_CTRL_RESET 2'h2
`define TSD_CLEAR_BIT 0

// Status register fields.
`define TSD_STAT_CLEAR_PIN 16
`define TSD_STAT_FULL 17

// Bus responses.
`define TSD_RESP_OKAY 2'h0
`define TSD_RESP_SLVERR 2'h2

`endif

// ==== tsd_tap_segment.v ====
`timescale 1ns/10ps

module tsd_tap_segment #(
    parameter WIDTH = 8,
    parameter DEPTH = 3,
    parameter INIT_ZERO = 1
) (
    // Clock and clears.
    input wire clk_i,
    input wire rst_n_i,
    input wire aclr_i,
    input wire sync_clr_i,
    // Chain data.
    input wire shift_i,
    input wire [WIDTH-1:0] din_i,
    output wire [WIDTH-1:0] dout_o
);

localparam PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
localparam [PTR_W-1:0] LAST = DEPTH - 1;

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [DEPTH-1:0] valid;
reg [PTR_W-1:0] ptr;

////////////////////////////////////////////////////////////////////////
// A memory array cannot be wiped in one step, so each word carries a
// valid flag; the flags clear at once and, with INIT_ZERO set, mask stale contents.
always @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
        valid <= {DEPTH{1'b0}};
        ptr <= {PTR_W{1'b0}};
    end else if (!rst_n_i || sync_clr_i) begin
        valid <= {DEPTH{1'b0}};
        ptr <= {PTR_W{1'b0}};
    end else if (shift_i) begin
        valid[ptr] <= 1'b1;
        ptr <= (ptr == LAST) ? {PTR_W{1'b0}} : ptr + 1'b1;
    end
end

always @(posedge clk_i) begin
    if (shift_i && !aclr_i) begin
        mem[ptr] <= din_i;
    end
end

////////////////////////////////////////////////////////////////////////
// The word under the registered pointer was written DEPTH shifts ago.
wire word_ok = (INIT_ZERO != 0) ? valid[ptr] : 1'b1;
assign dout_o = (aclr_i || !word_ok) ? {WIDTH{1'b0}} : mem[ptr];

endmodule

// ==== tsd_tap_select.v ====
`timescale 1ns/10ps

module tsd_tap_select #(
    parameter WIDTH = 8,
    parameter TAP_COUNT = 4
) (
    // Tap bus and selection.
    input wire [WIDTH*TAP_COUNT-1:0] taps_i,
    input wire [7:0] sel_i,
    // Selected word, zero when the index is out of range.
    output reg [WIDTH-1:0] word_o
);

integer i;

always @* begin
    word_o = {WIDTH{1'b0}};
    for (i = 0; i < TAP_COUNT; i = i + 1) begin
        if (sel_i == i[7:0]) begin
            word_o = taps_i[i*WIDTH +: WIDTH];
        end
    end
end

endmodule

// ==== tsd_shift_taps.v ====
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tsd_defines.vh"

// Notes on behaviour
// - Whole input word shifts in at once.
// - Shift only on edges with advance enable.
// - Without enable port, shift every edge.
// - Asynchronous clear erases chain without clock; with INIT_ZERO at 0 the stored words reappear once it ends.
// - Clear forces end and taps to zero.
// - Chain-end output carries the oldest word.
// - Tap bus is width times tap count.
// - Top tap group equals chain-end output.
// - Taps evenly spaced, all concatenated.
// - Spacing sets memory words per segment.
// - Zero or unknown starting contents.
// - Only memory addresses are registered.
// - Each tap readable as separate word.
// - Configurable tap count, regular points.
// - Lowest tap shows word after m shifts.
// - No shift when enable low.

module tsd_shift_taps #(
    parameter WIDTH = `TSD_DEF_WIDTH,
    parameter TAP_COUNT = `TSD_DEF_TAP_COUNT,
    parameter TAP_DISTANCE = `TSD_DEF_TAP_DISTANCE,
    parameter HAS_ENABLE = 1,
    parameter HAS_CLEAR = 1,
    parameter INIT_ZERO = 1
) (
    // Clock and reset.
    input wire CLOCK_I,
    input wire RESET_N_I,
    // Chain input side.
    input wire [WIDTH-1:0] SHIFT_IN_I,
    input wire ADVANCE_EN_I,
    input wire CLEAR_I,
    // Chain outputs.
    output wire [WIDTH-1:0] SHIFT_OUT_O,
    output wire [WIDTH*TAP_COUNT-1:0] TAPS_O,
    output wire [WIDTH-1:0] TAP_GROUP_LOWEST_O,
    // AXI4-Lite write address channel.
    input wire [`TSD_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire [2:0] S_AXI_AWPROT_I,
    input wire S_AXI_AWVALID_I,
    output wire S_AXI_AWREADY_O,
    // AXI4-Lite write data channel.
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output wire S_AXI_WREADY_O,
    // AXI4-Lite write response channel.
    output wire [1:0] S_AXI_BRESP_O,
    output wire S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    // AXI4-Lite read address channel.
    input wire [`TSD_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire [2:0] S_AXI_ARPROT_I,
    input wire S_AXI_ARVALID_I,
    output wire S_AXI_ARREADY_O,
    // AXI4-Lite read data channel.
    output wire [31:0] S_AXI_RDATA_O,
    output wire [1:0] S_AXI_RRESP_O,
    output wire S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I
);

localparam TAPS_W = WIDTH * TAP_COUNT;
localparam CHAIN_LEN = TAP_COUNT * TAP_DISTANCE;
localparam [7:0] P_WIDTH = WIDTH;
localparam [7:0] P_TAPS = TAP_COUNT;
localparam [7:0] P_DIST = TAP_DISTANCE;
localparam [15:0] P_LEN = CHAIN_LEN;

////////////////////////////////////////////////////////////////////////
// Helpers.

function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
        merge_bytes = old_val;
        for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
                merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
    end
endfunction

function is_mapped;
    input [`TSD_ADDR_W-1:0] addr;
    begin
        case (addr)
            `TSD_ADDR_CTRL,
            `TSD_ADDR_CLEAR,
            `TSD_ADDR_PUSH,
            `TSD_ADDR_STATUS,
            `TSD_ADDR_TAP_SEL,
            `TSD_ADDR_TAP_DATA,
            `TSD_ADDR_PARAMS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Register state.

reg [1:0] ctrl;
reg [7:0] tap_sel;
reg [WIDTH-1:0] push_word;
reg push_pulse;
reg soft_clear;
reg [15:0] shift_count;

wire src_sw = ctrl[`TSD_CTRL_SRC_SW];
wire pin_gate = ctrl[`TSD_CTRL_PIN_GATE];

////////////////////////////////////////////////////////////////////////
// Chain control.

// An absent enable port reads as constantly high.
wire pin_enable = (HAS_ENABLE != 0) ? ADVANCE_EN_I : 1'b1;
wire aclr = (HAS_CLEAR != 0) ? CLEAR_I : 1'b0;

// Software pushes replace the pin source entirely, so the two sources
// never compete for the same edge. Either source still needs the enable,
// and a software clear waits for it too, so with a low enable only the clear
// pin or a reset disturbs the outputs.
wire shift = pin_enable & (src_sw ? push_pulse : pin_gate);
wire clear_now = soft_clear & pin_enable;
wire [WIDTH-1:0] chain_in = src_sw ? push_word : SHIFT_IN_I;

wire [TAPS_W-1:0] taps;

genvar g;
generate
    for (g = 0; g < TAP_COUNT; g = g + 1) begin : seg
        wire [WIDTH-1:0] seg_in;
        if (g == 0) begin : first
            assign seg_in = chain_in;
        end else begin : later
            assign seg_in = taps[(g-1)*WIDTH +: WIDTH];
        end
        tsd_tap_segment #(
            .WIDTH(WIDTH),
            .DEPTH(TAP_DISTANCE),
            .INIT_ZERO(INIT_ZERO)
        ) u_seg (
            .clk_i(CLOCK_I),
            .rst_n_i(RESET_N_I),
            .aclr_i(aclr),
            .sync_clr_i(clear_now),
            .shift_i(shift),
            .din_i(seg_in),
            .dout_o(taps[g*WIDTH +: WIDTH])
        );
    end
endgenerate

// Data leaves the memory unregistered; the addresses carry the timing.
assign TAPS_O = taps;
assign TAP_GROUP_LOWEST_O = taps[WIDTH-1:0];
assign SHIFT_OUT_O = taps[TAPS_W-1 -: WIDTH];

////////////////////////////////////////////////////////////////////////
// Shift counter for status; saturates rather than wrapping so that the
// full flag stays trustworthy on long runs.
always @(posedge CLOCK_I or posedge aclr) begin
    if (aclr) begin
        shift_count <= 16'h0000;
    end else if (!RESET_N_I || clear_now) begin
        shift_count <= 16'h0000;
    end else if (shift && shift_count != 16'hffff) begin
        shift_count <= shift_count + 16'h0001;
    end
end

wire chain_full = (shift_count >= P_LEN);

////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path. Address and data are caught separately, in
// either order; the write happens once both are held.

reg aw_held;
reg [`TSD_ADDR_W-1:0] aw_addr;
reg w_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg bvalid;
reg [1:0] bresp;

wire do_write = aw_held & w_held & ~bvalid;
wire [31:0] ctrl_merged = merge_bytes({30'h0, ctrl}, w_data, w_strb);
wire [31:0] sel_merged = merge_bytes({24'h0, tap_sel}, w_data, w_strb);
wire [WIDTH+31:0] w_data_ext = {{WIDTH{1'b0}}, w_data};

assign S_AXI_AWREADY_O = ~aw_held & ~bvalid;
assign S_AXI_WREADY_O = ~w_held & ~bvalid;
assign S_AXI_BVALID_O = bvalid;
assign S_AXI_BRESP_O = bresp;

always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
        aw_held <= 1'b0;
        aw_addr <= {`TSD_ADDR_W{1'b0}};
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        bvalid <= 1'b0;
        bresp <= `TSD_RESP_OKAY;
    end else begin
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= is_mapped(aw_addr) ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
        end else if (bvalid && S_AXI_BREADY_I) begin
            bvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Register updates driven by writes.

always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
        ctrl <= `TSD_CTRL_RESET;
        tap_sel <= 8'h00;
        push_word <= {WIDTH{1'b0}};
        push_pulse <= 1'b0;
        soft_clear <= 1'b0;
    end else begin
        // A pending push or clear is held until an enabled edge takes it.
        // Leaving the software source drops a push that is still waiting,
        // and a write of zero to the clear register withdraws a clear.
        push_pulse <= push_pulse & src_sw & ~pin_enable;
        soft_clear <= soft_clear & ~pin_enable;
        if (do_write) begin
            case (aw_addr)
                `TSD_ADDR_CTRL: begin
                    ctrl <= ctrl_merged[1:0];
                end
                `TSD_ADDR_CLEAR: begin
                    soft_clear <= w_data[`TSD_CLEAR_BIT] & w_strb[0];
                end
                `TSD_ADDR_PUSH: begin
                    // A push is only meaningful with the software source
                    // chosen; otherwise the word is dropped.
                    if (src_sw) begin
                        push_word <= w_data_ext[WIDTH-1:0];
                        push_pulse <= 1'b1;
                    end
                end
                `TSD_ADDR_TAP_SEL: begin
                    tap_sel <= sel_merged[7:0];
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path: one read at a time, answered on the same edge
// that takes the address.

reg rvalid;
reg [31:0] rdata;
reg [1:0] rresp;
reg [31:0] next_rdata;

wire [WIDTH-1:0] sel_word;
wire [WIDTH+31:0] sel_word_ext = {32'h00000000, sel_word};

tsd_tap_select #(
    .WIDTH(WIDTH),
    .TAP_COUNT(TAP_COUNT)
) u_sel (
    .taps_i(taps),
    .sel_i(tap_sel),
    .word_o(sel_word)
);

always @* begin
    next_rdata = 32'h00000000;
    case (S_AXI_ARADDR_I)
        `TSD_ADDR_CTRL: next_rdata = {30'h0, ctrl};
        `TSD_ADDR_PUSH: next_rdata = w_data_ext[31:0] & 32'h00000000;
        `TSD_ADDR_STATUS: begin
            next_rdata[15:0] = shift_count;
            next_rdata[`TSD_STAT_CLEAR_PIN] = aclr;
            next_rdata[`TSD_STAT_FULL] = chain_full;
        end
        `TSD_ADDR_TAP_SEL: next_rdata = {24'h0, tap_sel};
        `TSD_ADDR_TAP_DATA: next_rdata = sel_word_ext[31:0];
        `TSD_ADDR_PARAMS: begin
            next_rdata = {7'h0, (INIT_ZERO != 0), P_DIST, P_TAPS, P_WIDTH};
        end
        default: next_rdata = 32'h00000000;
    endcase
end

assign S_AXI_ARREADY_O = ~rvalid;
assign S_AXI_RVALID_O = rvalid;
assign S_AXI_RDATA_O = rdata;
assign S_AXI_RRESP_O = rresp;

always @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `TSD_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && !rvalid) begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= is_mapped(S_AXI_ARADDR_I) ? `TSD_RESP_OKAY : `TSD_RESP_SLVERR;
    end else if (rvalid && S_AXI_RREADY_I) begin
        rvalid <= 1'b0;
    end
end

endmodule

// ==== tsd_shift_taps_props.sv ====
`timescale 1ns/10ps
module tsd_shift_taps_props #(
    parameter WIDTH = 8,
    parameter TAP_COUNT = 4
) (
    // Chain.
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic [WIDTH-1:0] SHIFT_IN_I,
    input wire logic ADVANCE_EN_I,
    input wire logic CLEAR_I,
    input wire logic [WIDTH-1:0] SHIFT_OUT_O,
    input wire logic [WIDTH*TAP_COUNT-1:0] TAPS_O,
    input wire logic [WIDTH-1:0] TAP_GROUP_LOWEST_O,
    // Register bus.
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    localparam TOP = WIDTH*TAP_COUNT;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESET_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    // The spacing checks assume a distance of three, the smallest legal one.
    sequence steady3;
        (ADVANCE_EN_I && !CLEAR_I)[*3] ##1 !CLEAR_I;
    endsequence
    sequence idle_edge;
        !ADVANCE_EN_I && !CLEAR_I ##1 !CLEAR_I;
    endsequence
    sequence wr_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    top_group_a: assert property (SHIFT_OUT_O == TAPS_O[TOP-1 -: WIDTH])
        else $error("chain end differs from top tap group");
    lowest_copy_a: assert property (TAP_GROUP_LOWEST_O == TAPS_O[WIDTH-1:0])
        else $error("lowest group port differs from tap bus");
    clear_zero_a: assert property (CLEAR_I |-> ~|TAPS_O && ~|SHIFT_OUT_O)
        else $error("outputs not zero during clear");
    hold_taps_a: assert property (idle_edge |-> $stable(TAPS_O))
        else $error("taps moved without enable");
    shift_lowest_a: assert property (steady3 |-> TAP_GROUP_LOWEST_O == $past(SHIFT_IN_I, 3))
        else $error("lowest tap late or wrong");
    tap_spacing_a: assert property (steady3 |-> TAPS_O[TOP-1:WIDTH] == $past(TAPS_O[TOP-WIDTH-1:0], 3))
        else $error("tap groups not evenly spaced");
    bresp_delay_a: assert property (wr_taken |-> ##1 !S_AXI_BVALID_O ##1 S_AXI_BVALID_O)
        else $error("write response not on time");
    rdata_delay_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read data not on time");
    bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped early");
    rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped early");
    ar_refuse_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read address taken during pending read");
endmodule

bind tsd_shift_taps tsd_shift_taps_props #(.WIDTH(WIDTH), .TAP_COUNT(TAP_COUNT)) props_u (
    .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .SHIFT_IN_I(SHIFT_IN_I),
    .ADVANCE_EN_I(ADVANCE_EN_I), .CLEAR_I(CLEAR_I), .SHIFT_OUT_O(SHIFT_OUT_O),
    .TAPS_O(TAPS_O), .TAP_GROUP_LOWEST_O(TAP_GROUP_LOWEST_O),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I)
);

// ==== tsd_producer.sv ====
`timescale 1ns/10ps
module tsd_producer (
    // Clock and commands.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic stall_i,
    // Chain feed.
    output logic [7:0] word_o = 8'h00,
    output logic advance_o = 1'b0
);
    logic [7:0] seq = 8'h00;
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            seq <= 8'h00;
            advance_o <= 1'b0;
        end else if (run_i && !(stall_i && advance_o)) begin
            seq <= seq + 8'h3b;
            word_o <= seq ^ 8'ha5;
            advance_o <= 1'b1;
        end else begin
            // Idle data never repeats the last word, so a stray sample shows up.
            word_o <= ~word_o;
            advance_o <= 1'b0;
        end
    end
endmodule

// ==== tsd_shift_taps_test.sv ====
`timescale 1ns/10ps
module tsd_shift_taps_test;
    localparam W = 8;
    localparam N = 4;
    localparam M = 3;
    logic clk = 1'b0, rst_n = 1'b0, clr = 1'b0, run = 1'b0, stall = 1'b0, watch = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid, adv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [W-1:0] sin, sout, low;
    logic [W*N-1:0] taps;
    logic [W-1:0] hist [0:N*M-1];
    logic [W-1:0] fh [0:2];
    logic [W-1:0] pushw = 8'h00, low2;
    logic swsrc = 1'b0;
    integer failures = 0, checks = 0, nsh = 0, i, k, g;

    always #20 clk = ~clk;

    tsd_producer prod_u (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .stall_i(stall),
        .word_o(sin), .advance_o(adv));

    tsd_shift_taps #(.WIDTH(W), .TAP_COUNT(N), .TAP_DISTANCE(M)) dut_u (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .SHIFT_IN_I(sin), .ADVANCE_EN_I(adv),
        .CLEAR_I(clr), .SHIFT_OUT_O(sout), .TAPS_O(taps), .TAP_GROUP_LOWEST_O(low),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWPROT_I(3'h0), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARPROT_I(3'h0), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready));

    ////////////////////////////////////////////////////////////////////////////////
    // Reference chain, newest word at index zero.
    always @(posedge clk or posedge clr) begin
        if (clr || !rst_n) begin
            for (i = 0; i < N*M; i = i + 1) hist[i] <= 8'h00;
            nsh <= 0;
        end else if (adv) begin
            for (i = N*M-1; i > 0; i = i - 1) hist[i] <= hist[i-1];
            hist[0] <= swsrc ? pushw : sin;
            nsh <= nsh + 1;
        end
    end

    // Reference for the instance without enable or clear: shifts every edge.
    always @(posedge clk) begin
        fh[0] <= rst_n ? sin : 8'h00;
        fh[1] <= rst_n ? fh[0] : 8'h00;
        fh[2] <= rst_n ? fh[1] : 8'h00;
    end

    tsd_shift_taps #(.WIDTH(W), .TAP_COUNT(N), .TAP_DISTANCE(M), .HAS_ENABLE(0),
        .HAS_CLEAR(0)) free_u (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .SHIFT_IN_I(sin), .ADVANCE_EN_I(1'b1),
        .CLEAR_I(1'b0), .SHIFT_OUT_O(), .TAPS_O(), .TAP_GROUP_LOWEST_O(low2),
        .S_AXI_AWADDR_I(8'h00), .S_AXI_AWPROT_I(3'h0), .S_AXI_AWVALID_I(1'b0),
        .S_AXI_AWREADY_O(), .S_AXI_WDATA_I(32'h00000000), .S_AXI_WSTRB_I(4'h0),
        .S_AXI_WVALID_I(1'b0), .S_AXI_WREADY_O(), .S_AXI_BRESP_O(), .S_AXI_BVALID_O(),
        .S_AXI_BREADY_I(1'b0), .S_AXI_ARADDR_I(8'h00), .S_AXI_ARPROT_I(3'h0),
        .S_AXI_ARVALID_I(1'b0), .S_AXI_ARREADY_O(), .S_AXI_RDATA_O(),
        .S_AXI_RRESP_O(), .S_AXI_RVALID_O(), .S_AXI_RREADY_I(1'b0));

    always @(negedge clk) begin
        if (watch) begin
            for (k = 0; k < N; k = k + 1) check(taps[k*W +: W], hist[k*M+M-1]);
            check(sout, hist[N*M-1]);
            check(low, hist[M-1]);
            check(low2, fh[2]);
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task results;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    task bound(input integer n);
        begin
            if (n >= 40) begin
                failures = failures + 1;
                results;
            end
        end
    endtask

    // One edge to start the producer, one enabled edge, then two quiet edges.
    task pulse;
        begin
            run <= 1'b1;
            @(posedge clk);
            run <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        integer n;
        logic aw, w;
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            aw = 1'b0;
            w = 1'b0;
            for (n = 0; n < 40 && !(aw && w); n = n + 1) begin
                @(posedge clk);
                if (!aw && awready) begin
                    aw = 1'b1;
                    awvalid <= 1'b0;
                end
                if (!w && wready) begin
                    w = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            bound(n);
            for (n = 0; n < 40 && !bvalid; n = n + 1) @(posedge clk);
            bound(n);
            bready <= 1'b1;
            @(posedge clk);
            check(bresp, r);
            bready <= 1'b0;
        end
    endtask

    task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        integer n;
        begin
            araddr <= a;
            arvalid <= 1'b1;
            for (n = 0; n < 40 && !(arvalid && arready); n = n + 1) @(posedge clk);
            bound(n);
            arvalid <= 1'b0;
            for (n = 0; n < 40 && !rvalid; n = n + 1) @(posedge clk);
            bound(n);
            rready <= 1'b1;
            @(posedge clk);
            if (r == 2'h0) check(rdata, d);
            check(rresp, r);
            rready <= 1'b0;
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        watch = 1'b1;
        axr(8'h18, 32'h01030408, 2'h0);
        axr(8'h00, 32'h00000002, 2'h0);
        axr(8'h1c, 32'h00000000, 2'h2);
        axw(8'h1c, 32'h00000001, 2'h2);
        // Steady stream, then a stalled one that skips every other edge.
        run <= 1'b1;
        repeat (16) @(posedge clk);
        stall <= 1'b1;
        repeat (10) @(posedge clk);
        run <= 1'b0;
        stall <= 1'b0;
        @(posedge clk);
        for (g = 0; g <= N; g = g + 1) begin
            axw(8'h10, g, 2'h0);
            axr(8'h14, (g < N) ? {24'h000000, hist[g*M+M-1]} : 32'h00000000, 2'h0);
        end
        axr(8'h0c, {14'h0000, nsh >= N*M, 1'b0, nsh[15:0]}, 2'h0);
        // Software source: the push waits, unseen, for one enabled edge.
        pushw <= 8'h5a;
        axw(8'h00, 32'h00000003, 2'h0);
        swsrc <= 1'b1;
        axw(8'h08, 32'h0000005a, 2'h0);
        repeat (3) @(posedge clk);
        pulse;
        axw(8'h00, 32'h00000002, 2'h0);
        swsrc <= 1'b0;
        // A push in pin mode is dropped; the pin word shifts instead.
        axw(8'h08, 32'h000000ee, 2'h0);
        pulse;
        // A software clear also waits for the enable.
        watch = 1'b0;
        axw(8'h04, 32'h00000001, 2'h0);
        check(low, hist[M-1]);
        pulse;
        check(taps, 32'h00000000);
        axr(8'h0c, 32'h00000000, 2'h0);
        run <= 1'b1;
        repeat (5) @(posedge clk);
        clr <= 1'b1;
        #1;
        check(taps, 32'h00000000);
        check(sout, 32'h00000000);
        watch = 1'b1;
        repeat (3) @(posedge clk);
        clr <= 1'b0;
        repeat (20) @(posedge clk);
        results;
    end
endmodule
